// [hw/ocu_device.sv]
// two channel output compare unit of a 16-bit timer
`timescale 1ns/1ps
module ocu_device (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // host bus
  ocu_if.dev BUS,
  // counter side
  input wire logic TICK,
  input wire logic [15:0] COUNTER_VALUE,
  input wire logic [15:0] CAPTURE_VALUE_REG,
  output logic CNT_WRITE,
  output logic [15:0] CNT_WDATA,
  // port pins
  input wire logic [1:0] PORT_OUT,
  input wire logic [1:0] WAVE_PIN_DIRECTION,
  output logic [1:0] PIN_OUT,
  output logic [1:0] PIN_OE,
  output logic [1:0] WAVE_OUTPUT_STATE,
  output logic [1:0] MATCH,
  output logic [3:0] WAVEFORM_MODE_SEL
);
  typedef struct packed {
    logic [1:0][15:0] cmp;
    logic [1:0][15:0] buf_val;
    logic [7:0] temp;
    logic [1:0] flag;
    logic [1:0] irq_en;
    logic [1:0][1:0] act;
    logic [3:0] mode;
    logic [1:0] ocs;
    logic [1:0] pend;
    logic block;
    logic cnt_wr;
    logic [15:0] cnt_wdata;
    logic [7:0] rdata;
    logic [1:0] irq;
    logic [1:0] match;
    logic [1:0] pin;
    logic [1:0] oe;
  } state_t;

  state_t r;
  state_t next_r;

  function automatic logic is_pwm(input logic [3:0] m);
    return !(m == ocu_pkg::MODE_NORMAL || m == ocu_pkg::MODE_CTC_A
      || m == ocu_pkg::MODE_CTC_CAP);
  endfunction : is_pwm

  function automatic logic [15:0] top_of(input logic [3:0] m, input logic [15:0] cmp_a,
      input logic [15:0] cap);
    unique case (m)
      ocu_pkg::MODE_FAST8: return ocu_pkg::TOP_8;
      ocu_pkg::MODE_FAST9: return ocu_pkg::TOP_9;
      ocu_pkg::MODE_FAST10: return ocu_pkg::TOP_10;
      ocu_pkg::MODE_CTC_A, ocu_pkg::MODE_FAST_A: return cmp_a;
      ocu_pkg::MODE_CTC_CAP, ocu_pkg::MODE_FAST_CAP: return cap;
      default: return ocu_pkg::CNT_MAX;
    endcase
  endfunction : top_of

  // non-PWM action on match or force
  function automatic logic act_np(input logic [1:0] a, input logic o);
    unique case (a)
      ocu_pkg::ACT_NONE: return o;
      ocu_pkg::ACT_TOGGLE: return !o;
      ocu_pkg::ACT_CLEAR: return 1'b0;
      ocu_pkg::ACT_SET: return 1'b1;
    endcase
  endfunction : act_np

  logic [15:0] top;
  logic pwm;

  always_comb begin
    next_r = r;
    pwm = is_pwm(r.mode);
    top = top_of(r.mode, r.cmp[0], CAPTURE_VALUE_REG);
    next_r.cnt_wr = 1'b0;
    next_r.rdata = r.rdata;
    for (int c = 0; c < ocu_pkg::NCH; c++) begin
      next_r.match[c] = (COUNTER_VALUE == r.cmp[c]);
      if (TICK) begin
        // flag rises on the tick after equality was seen
        if (r.pend[c]) begin
          next_r.flag[c] = 1'b1;
          if (pwm) begin
            next_r.ocs[c] = r.act[c] == ocu_pkg::ACT_CLEAR ? 1'b0
              : r.act[c] == ocu_pkg::ACT_SET ? 1'b1 : r.ocs[c];
          end else begin
            next_r.ocs[c] = act_np(r.act[c], r.ocs[c]);
          end
        end
        // a match seen at this tick only takes effect at the next one
        next_r.pend[c] = r.match[c] && !r.block;
        if (pwm && COUNTER_VALUE == ocu_pkg::CNT_BOTTOM) begin
          if (r.act[c] == ocu_pkg::ACT_CLEAR) next_r.ocs[c] = 1'b1;
          if (r.act[c] == ocu_pkg::ACT_SET) next_r.ocs[c] = 1'b0;
        end
        // reloading only at the ends keeps every pwm period whole
        if (pwm && (COUNTER_VALUE == top || COUNTER_VALUE == ocu_pkg::CNT_BOTTOM)) begin
          next_r.cmp[c] = r.buf_val[c];
        end
      end
    end
    // block lasts until the next tick, so a stopped timer keeps it armed
    if (TICK) next_r.block = 1'b0;
    // interrupt service clears the flag
    for (int c = 0; c < ocu_pkg::NCH; c++) begin
      if (BUS.irq_ack[c] && !(TICK && r.pend[c])) next_r.flag[c] = 1'b0;
    end
    if (BUS.io_wr) begin
      unique case (BUS.io_addr)
        ocu_pkg::ADDR_CMP_A_HI, ocu_pkg::ADDR_CMP_B_HI: next_r.temp = BUS.io_wdata;
        ocu_pkg::ADDR_CMP_A_LO, ocu_pkg::ADDR_CMP_B_LO: begin
          if (pwm) next_r.buf_val[BUS.io_addr[1]] = {r.temp, BUS.io_wdata};
          else next_r.cmp[BUS.io_addr[1]] = {r.temp, BUS.io_wdata};
        end
        ocu_pkg::ADDR_CTRL: begin
          // mode change leaves ocs alone
          next_r.mode = BUS.io_wdata[3:0];
          next_r.act[0] = BUS.io_wdata[5:4];
          next_r.act[1] = BUS.io_wdata[7:6];
        end
        ocu_pkg::ADDR_FLAGS: begin
          for (int c = 0; c < ocu_pkg::NCH; c++) begin
            // a set arriving this tick wins over the clear
            if (BUS.io_wdata[c] && !(TICK && r.pend[c])) next_r.flag[c] = 1'b0;
          end
          next_r.irq_en = BUS.io_wdata[5:4];
        end
        ocu_pkg::ADDR_FORCE: begin
          for (int c = 0; c < ocu_pkg::NCH; c++) begin
            if (BUS.io_wdata[c] && !pwm) next_r.ocs[c] = act_np(r.act[c], r.ocs[c]);
          end
        end
        ocu_pkg::ADDR_CNT_WR: begin
          // low byte write with temp as high byte, like the compare path
          next_r.cnt_wr = 1'b1;
          next_r.cnt_wdata = {r.temp, BUS.io_wdata};
          next_r.block = 1'b1;
          next_r.pend = '0;
        end
      endcase
    end
    if (BUS.io_rd) begin
      unique case (BUS.io_addr)
        ocu_pkg::ADDR_CMP_A_LO, ocu_pkg::ADDR_CMP_B_LO:
          next_r.rdata = pwm ? r.buf_val[BUS.io_addr[1]][7:0] : r.cmp[BUS.io_addr[1]][7:0];
        ocu_pkg::ADDR_CMP_A_HI, ocu_pkg::ADDR_CMP_B_HI:
          next_r.rdata = pwm ? r.buf_val[BUS.io_addr[1]][15:8] : r.cmp[BUS.io_addr[1]][15:8];
        ocu_pkg::ADDR_CTRL: next_r.rdata = {r.act[1], r.act[0], r.mode};
        ocu_pkg::ADDR_FLAGS: next_r.rdata = {2'b00, r.irq_en, 2'b00, r.flag};
        ocu_pkg::ADDR_FORCE: next_r.rdata = {6'b00_0000, r.ocs};
        ocu_pkg::ADDR_CNT_WR: next_r.rdata = COUNTER_VALUE[7:0];
      endcase
    end
    // request follows this cycle's flag, so an ack drops it at once
    next_r.irq = next_r.flag & next_r.irq_en;
    for (int c = 0; c < ocu_pkg::NCH; c++) begin
      next_r.pin[c] = (next_r.act[c] != ocu_pkg::ACT_NONE) ? next_r.ocs[c] : PORT_OUT[c];
    end
    // the override changes only the value; direction stays with the port
    next_r.oe = WAVE_PIN_DIRECTION;
  end

  always_ff @(posedge CLK) begin
    if (RST) r <= '0;
    else r <= next_r;
  end

  assign BUS.io_rdata = r.rdata;
  assign BUS.irq = r.irq;
  assign CNT_WRITE = r.cnt_wr;
  assign CNT_WDATA = r.cnt_wdata;
  assign PIN_OUT = r.pin;
  assign PIN_OE = r.oe;
  assign WAVE_OUTPUT_STATE = r.ocs;
  assign MATCH = r.match;
  assign WAVEFORM_MODE_SEL = r.mode;
endmodule : ocu_device

// [hw/ocu_pkg.sv]
// shared constants for the output compare unit and its host
package ocu_pkg;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int MODE_W = 4;
  localparam int ACT_W = 2;
  localparam int NCH = 2;
  // waveform modes
  localparam logic [3:0] MODE_NORMAL = 4'h0;
  localparam logic [3:0] MODE_CTC_A = 4'h4;
  localparam logic [3:0] MODE_FAST8 = 4'h5;
  localparam logic [3:0] MODE_FAST9 = 4'h6;
  localparam logic [3:0] MODE_FAST10 = 4'h7;
  localparam logic [3:0] MODE_CTC_CAP = 4'hC;
  localparam logic [3:0] MODE_FAST_CAP = 4'hE;
  localparam logic [3:0] MODE_FAST_A = 4'hF;
  // output action encodings
  localparam logic [1:0] ACT_NONE = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR = 2'h2;
  localparam logic [1:0] ACT_SET = 2'h3;
  // byte addresses on the host bus
  localparam logic [2:0] ADDR_CMP_A_LO = 3'h0;
  localparam logic [2:0] ADDR_CMP_A_HI = 3'h1;
  localparam logic [2:0] ADDR_CMP_B_LO = 3'h2;
  localparam logic [2:0] ADDR_CMP_B_HI = 3'h3;
  localparam logic [2:0] ADDR_CTRL = 3'h4;
  localparam logic [2:0] ADDR_FLAGS = 3'h5;
  localparam logic [2:0] ADDR_FORCE = 3'h6;
  localparam logic [2:0] ADDR_CNT_WR = 3'h7;
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hFFFF;
  localparam logic [15:0] TOP_8 = 16'h00FF;
  localparam logic [15:0] TOP_9 = 16'h01FF;
  localparam logic [15:0] TOP_10 = 16'h03FF;
  // apb register offsets of the host controller
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_STATUS = 8'h04;
  localparam logic [7:0] APB_RDATA = 8'h08;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_WR_BIT = 16;
endpackage : ocu_pkg

// [hw/ocu_if.sv]
// link between the host cpu byte bus and the output compare unit
`timescale 1ns/1ps
interface ocu_if;
  logic [2:0] io_addr;
  logic io_wr;
  logic io_rd;
  logic [7:0] io_wdata;
  logic [7:0] io_rdata;
  logic [1:0] irq;
  logic [1:0] irq_ack;
  modport dev (input io_addr, io_wr, io_rd, io_wdata, irq_ack, output io_rdata, irq);
  modport host (output io_addr, io_wr, io_rd, io_wdata, irq_ack, input io_rdata, irq);
endinterface : ocu_if

// [hw/ocu_host.sv]
// host side: apb command registers driving the byte bus of the compare unit
`timescale 1ns/1ps
module ocu_host (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // device link
  ocu_if.host BUS
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_CAPTURE = 2'b10
  } phase_t;

  typedef struct packed {
    phase_t ph;
    logic [2:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [1:0] ack;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } state_t;

  state_t r;
  state_t next_r;
  logic access;

  always_comb begin
    next_r = r;
    access = PSEL && PENABLE && !r.pready;
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    next_r.wr = 1'b0;
    next_r.rd = 1'b0;
    next_r.ack = '0;
    unique case (r.ph)
      ST_IDLE: begin
        if (access) begin
          next_r.pready = 1'b1;
          next_r.prdata = '0;
          unique case (PADDR)
            ocu_pkg::APB_CMD: begin
              if (PWRITE) begin
                // byte access to the device; 16-bit values go high byte first
                next_r.addr = PWDATA[ocu_pkg::CMD_ADDR_LSB +: 3];
                next_r.wdata = PWDATA[7:0];
                next_r.wr = PWDATA[ocu_pkg::CMD_WR_BIT];
                next_r.rd = !PWDATA[ocu_pkg::CMD_WR_BIT];
                next_r.ph = ST_ISSUE;
              end
            end
            ocu_pkg::APB_STATUS: begin
              // write-one acknowledges an interrupt, clearing its flag
              if (PWRITE) next_r.ack = PWDATA[1:0];
              else next_r.prdata = {29'h0000_0000, r.ph != ST_IDLE, BUS.irq};
            end
            ocu_pkg::APB_RDATA: next_r.prdata = {24'h00_0000, r.rdata};
            default: next_r.pslverr = 1'b1;
          endcase
        end
      end
      ST_ISSUE: next_r.ph = ST_CAPTURE;
      ST_CAPTURE: begin
        // device answers one cycle after the read strobe
        next_r.rdata = BUS.io_rdata;
        next_r.ph = ST_IDLE;
      end
      default: next_r.ph = ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) r <= '0;
    else r <= next_r;
  end

  assign PRDATA = r.prdata;
  assign PREADY = r.pready;
  assign PSLVERR = r.pslverr;
  assign BUS.io_addr = r.addr;
  assign BUS.io_wr = r.wr;
  assign BUS.io_rd = r.rd;
  assign BUS.io_wdata = r.wdata;
  assign BUS.irq_ack = r.ack;
endmodule : ocu_host

// [tb/ocu_link_monitor.sv]
// concurrent checks on the byte link and pins between host and compare unit
`timescale 1ns/1ps
module ocu_link_monitor (
  // clock and reset
  input wire logic CLK,
  input wire logic RST,
  // byte link
  input wire logic [2:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_rdata,
  input wire logic [1:0] irq,
  input wire logic [1:0] irq_ack,
  // device pins
  input wire logic TICK,
  input wire logic CNT_WRITE,
  input wire logic [1:0] WAVE_PIN_DIRECTION,
  input wire logic [1:0] PIN_OE,
  input wire logic [1:0] WAVE_OUTPUT_STATE
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);
  logic clr_req;
  logic frc_wr;
  // any flag or enable write may lower or raise a request
  assign clr_req = (|irq_ack) || (io_wr && io_addr == ocu_pkg::ADDR_FLAGS);
  assign frc_wr = io_wr && io_addr == ocu_pkg::ADDR_FORCE;
  a_reset_clears_out: assert property ($fell(RST) |-> WAVE_OUTPUT_STATE == 2'h0 && irq == 2'h0)
    else $error("outputs not cleared by reset");
  a_wave_change_cause: assert property ($changed(WAVE_OUTPUT_STATE) |-> $past(TICK) || $past(frc_wr))
    else $error("wave state moved without tick or force");
  a_pin_dir_follows: assert property (!$past(RST) |-> PIN_OE == $past(WAVE_PIN_DIRECTION))
    else $error("pin enable does not follow direction");
  a_link_single_op: assert property (io_wr || io_rd |=> !io_wr && !io_rd)
    else $error("link strobe longer than one cycle");
  a_rdata_holds: assert property (!io_rd |=> $stable(io_rdata))
    else $error("read data changed without a read");
  a_irq_drop_cause: assert property (|(~irq & $past(irq)) |->
    $past(clr_req) || $past(clr_req, 2) || $past(clr_req, 3))
    else $error("request dropped without ack or flag write");
  a_irq_rise_cause: assert property (|(irq & ~$past(irq)) |->
    $past(TICK) || $past(clr_req))
    else $error("request raised without tick or enable");
  a_cnt_write_pulse: assert property (io_wr && io_addr == ocu_pkg::ADDR_CNT_WR |=>
    CNT_WRITE ##1 !CNT_WRITE)
    else $error("counter write strobe wrong");
  c_force: cover property (frc_wr);
  c_irq: cover property ($rose(irq[0]));
  c_ack: cover property (|irq_ack);
endmodule : ocu_link_monitor

// [tb/tb_output_compare_unit_16bit.sv]
// self-checking bench: apb commands reach the compare unit over the byte link
`timescale 1ns/1ps
module tb_output_compare_unit_16bit;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, err, tick, cnt_write;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [15:0] cval, cnt_wdata;
  logic [1:0] port_out, dir, pin_out, pin_oe, ocs, match;
  logic [3:0] wmode;
  logic [1:0] acts [5];
  logic [4:0] exps;
  int n_mismatch, check_count;
  ocu_if link ();
  ocu_host ocu_host_inst (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BUS(link.host));
  ocu_device ocu_device_inst (.CLK(clk), .RST(rst), .BUS(link.dev), .TICK(tick),
    .COUNTER_VALUE(cval), .CAPTURE_VALUE_REG(16'h0000), .CNT_WRITE(cnt_write),
    .CNT_WDATA(cnt_wdata), .PORT_OUT(port_out), .WAVE_PIN_DIRECTION(dir), .PIN_OUT(pin_out),
    .PIN_OE(pin_oe), .WAVE_OUTPUT_STATE(ocs), .MATCH(match), .WAVEFORM_MODE_SEL(wmode));
  ocu_link_monitor ocu_link_monitor_inst (.CLK(clk), .RST(rst), .io_addr(link.io_addr),
    .io_wr(link.io_wr), .io_rd(link.io_rd), .io_rdata(link.io_rdata), .irq(link.irq),
    .irq_ack(link.irq_ack), .TICK(tick), .CNT_WRITE(cnt_write), .WAVE_PIN_DIRECTION(dir),
    .PIN_OE(pin_oe), .WAVE_OUTPUT_STATE(ocs));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run
  // request held until the edge that samples pready high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do @(posedge clk); while (pready !== 1'h1);
    r = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb
  // one byte access on the link, waiting for the host to go idle
  task automatic dev(input logic w, input logic [2:0] a, input logic [7:0] d);
    apb(1'h1, ocu_pkg::APB_CMD, (32'(w) << ocu_pkg::CMD_WR_BIT) |
      (32'(a) << ocu_pkg::CMD_ADDR_LSB) | 32'(d));
    do apb(1'h0, ocu_pkg::APB_STATUS, 32'h0000_0000); while (r[2] === 1'h1);
    if (!w) apb(1'h0, ocu_pkg::APB_RDATA, 32'h0000_0000);
  endtask : dev
  task automatic rc(input logic [2:0] a, input logic [7:0] m, input logic [7:0] e);
    dev(1'h0, a, 8'h00);
    chk(16'(r[7:0] & m), 16'(e));
  endtask : rc
  // counter value settles a cycle before the timer tick samples the match
  task automatic step(input logic [15:0] v);
    @(posedge clk);
    cval <= v;
    @(posedge clk);
    tick <= 1'h1;
    @(posedge clk);
    tick <= 1'h0;
    // results launched by the tick edge are read one edge later
    @(posedge clk);
  endtask : step
  initial begin
    clk = 1'h0;
    forever #2 clk = ~clk;
  end
  initial begin
    #100000;
    n_mismatch++;
    complete_run();
  end
  initial begin
    {rst, psel, penable, pwrite, paddr, pwdata, tick, cval, dir} = '0;
    rst = 1'h1;
    port_out = 2'h2;
    n_mismatch = 0;
    check_count = 0;
    acts = '{ocu_pkg::ACT_SET, ocu_pkg::ACT_NONE, ocu_pkg::ACT_TOGGLE, ocu_pkg::ACT_SET,
      ocu_pkg::ACT_CLEAR};
    exps = 5'h0B;
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rc(ocu_pkg::ADDR_FORCE, 8'h03, 8'h00);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h00);
    apb(1'h0, 8'h0C, 32'h0000_0000);
    chk(16'(err), 16'h0001);
    $display("test reset done");
    dev(1'h1, ocu_pkg::ADDR_CMP_B_HI, 8'h56);
    dev(1'h1, ocu_pkg::ADDR_CMP_B_LO, 8'h78);
    rc(ocu_pkg::ADDR_CMP_B_HI, 8'hFF, 8'h56);
    rc(ocu_pkg::ADDR_CMP_B_LO, 8'hFF, 8'h78);
    dev(1'h1, ocu_pkg::ADDR_CMP_A_HI, 8'h12);
    dev(1'h1, ocu_pkg::ADDR_CMP_A_LO, 8'h34);
    rc(ocu_pkg::ADDR_CMP_A_HI, 8'hFF, 8'h12);
    rc(ocu_pkg::ADDR_CMP_A_LO, 8'hFF, 8'h34);
    dev(1'h1, ocu_pkg::ADDR_CNT_WR, 8'h34);
    chk(cnt_wdata, 16'h1234);
    step(16'h1234);
    step(16'h1235);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h00);
    $display("test access done");
    dev(1'h1, ocu_pkg::ADDR_CTRL, {2'h0, ocu_pkg::ACT_TOGGLE, ocu_pkg::MODE_CTC_A});
    dir <= 2'h3;
    step(16'h1234);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h00);
    step(16'h0000);
    chk(16'(ocs), 16'h0001);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h01);
    chk(16'(pin_out), 16'h0003);
    chk(16'(pin_oe), 16'h0003);
    dev(1'h1, ocu_pkg::ADDR_FLAGS, 8'h00);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h01);
    dev(1'h1, ocu_pkg::ADDR_FLAGS, 8'h11);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h00);
    step(16'h1234);
    step(16'h0000);
    chk(16'(ocs), 16'h0000);
    apb(1'h0, ocu_pkg::APB_STATUS, 32'h0000_0000);
    chk(16'(r[1:0]), 16'h0001);
    apb(1'h1, ocu_pkg::APB_STATUS, 32'h0000_0001);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h00);
    $display("test match done");
    for (int i = 0; i < 5; i++) begin
      dev(1'h1, ocu_pkg::ADDR_CTRL, {2'h0, acts[i], ocu_pkg::MODE_NORMAL});
      dev(1'h1, ocu_pkg::ADDR_FORCE, 8'h01);
      chk(16'(ocs), 16'(exps[i]));
    end
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h00);
    $display("test force done");
    dev(1'h1, ocu_pkg::ADDR_CTRL, {ocu_pkg::ACT_SET, ocu_pkg::ACT_NONE, ocu_pkg::MODE_NORMAL});
    dev(1'h1, ocu_pkg::ADDR_FORCE, 8'h02);
    chk(16'(ocs), 16'h0002);
    dev(1'h1, ocu_pkg::ADDR_CTRL, {2'h0, ocu_pkg::ACT_CLEAR, ocu_pkg::MODE_FAST8});
    chk(16'(ocs), 16'h0002);
    chk(16'(wmode), 16'(ocu_pkg::MODE_FAST8));
    dev(1'h1, ocu_pkg::ADDR_CMP_A_HI, 8'h00);
    dev(1'h1, ocu_pkg::ADDR_CMP_A_LO, 8'h10);
    rc(ocu_pkg::ADDR_CMP_A_LO, 8'hFF, 8'h10);
    step(16'h0010);
    step(16'h0011);
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h00);
    step(16'h00FF);
    step(16'h0000);
    step(16'h0010);
    chk(16'(ocs), 16'h0003);
    chk(16'(match), 16'h0001);
    step(16'h0011);
    chk(16'(ocs), 16'h0002);
    // channel B buffer still holds zero; loaded at top, it matches at bottom
    rc(ocu_pkg::ADDR_FLAGS, 8'h03, 8'h03);
    $display("test buffer done");
    complete_run();
  end
endmodule : tb_output_compare_unit_16bit
